//--- core/nao_defs.svh
// Constants of the normal-average oversampling engine.
// Assumes a 40 MHz core clock and a 16-bit setup word.
`ifndef NAO_DEFS_SVH
`define NAO_DEFS_SVH
`define STYLE_BIT 9
`define RATIO_MSB 8
`define RATIO_LSB 6
`define RATIO_MAX 3'h5
`define RATIO_LATENCY 2'h2
`define BOOST_BITS 2
`define RATIO_RESET 3'h0
`define CLOCK_KHZ 40000
`define BURST_RATE_KSPS 3000
`define PACE_CYCLES ((`CLOCK_KHZ + `BURST_RATE_KSPS - 1) / `BURST_RATE_KSPS)
`endif

//--- core/nao_pkg.sv
// Types shared by the oversampling engine.
// Assumes nothing of its surroundings.
package nao_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_PACE} burst_state_e;
  typedef logic [2:0] ratio_code_t;
endpackage

//--- core/channel_accumulator.sv
// Signed running sum of one converter channel.
// Assumes samples and strobes come from logic on the same clock.
`timescale 1ns/10ps
module channel_accumulator #(
  parameter int SAMPLE_W = 16,
  parameter int SUM_W = 23
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic add,
  input wire logic [SAMPLE_W-1:0] sample,
  output logic [SUM_W-1:0] sum
);
  if (SUM_W < SAMPLE_W + 5) begin : g_width_check
    $error("Sum too narrow for 32 samples");
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sum <= '0;
    end else if (clear) begin
      sum <= '0;
    end else if (add) begin
      sum <= sum + {{(SUM_W-SAMPLE_W){sample[SAMPLE_W-1]}}, sample};
    end
  end
endmodule

//--- core/normal_average_oversampler.sv
// Normal-average oversampling engine for two simultaneous channels.
// Assumes a conversion core on the same clock; cs_b and sclk are pins.
`timescale 1ns/10ps
`include "nao_defs.svh"
module normal_average_oversampler #(
  parameter int SAMPLE_W = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic setup_write,
  input wire logic [15:0] setup_data,
  input wire logic extra_resolution_enable,
  input wire logic cs_b,
  input wire logic sclk,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  output logic sdo_a,
  output logic sdo_b,
  output logic result_ready,
  output logic [4:0] result_bits,
  output logic burst_busy,
  output logic rolling_selected
);
  localparam int SUM_W = SAMPLE_W + 7;
  localparam int OUT_W = SAMPLE_W + `BOOST_BITS;
  localparam logic [4:0] PACE_LAST = 5'(`PACE_CYCLES - 1);

  if (SAMPLE_W != 16 && SAMPLE_W != 14) begin : g_width_check
    $error("SAMPLE_W must be 16 or 14");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic cs_b_m, cs_b_s, cs_b_d, sclk_m, sclk_s, sclk_d;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {cs_b_m, cs_b_s, cs_b_d} <= 3'h7;
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
    end else begin
      {cs_b_m, cs_b_s, cs_b_d} <= {cs_b, cs_b_m, cs_b_s};
      {sclk_m, sclk_s, sclk_d} <= {sclk, sclk_m, sclk_s};
    end
  end
  logic cs_fall, sclk_fall;
  assign cs_fall = cs_b_d & ~cs_b_s;
  assign sclk_fall = sclk_d & ~sclk_s & ~cs_b_s;

  // ****************************************
  // Setup fields and ratio latency
  // ****************************************
  logic style;
  nao_pkg::ratio_code_t ratio_active, ratio_pending;
  logic [1:0] pend_cnt;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      style <= 1'b0;
      ratio_active <= `RATIO_RESET;
      ratio_pending <= `RATIO_RESET;
      pend_cnt <= 2'h0;
    end else if (setup_write) begin
      style <= setup_data[`STYLE_BIT];
      ratio_pending <= setup_data[`RATIO_MSB:`RATIO_LSB];
      pend_cnt <= `RATIO_LATENCY;
    end else if (conv_done && pend_cnt != 2'h0) begin
      pend_cnt <= pend_cnt - 2'h1;
      if (pend_cnt == 2'h1) begin
        ratio_active <= ratio_pending;
      end
    end
  end

  logic ratio_valid, avg_on;
  assign ratio_valid = ratio_active != 3'h0 && ratio_active <= `RATIO_MAX;
  assign avg_on = !style && ratio_valid;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rolling_selected <= 1'b0;
    end else begin
      rolling_selected <= style && ratio_active != 3'h0;
    end
  end

  // ****************************************
  // Burst sequencer
  // ****************************************
  nao_pkg::burst_state_e state;
  nao_pkg::ratio_code_t burst_code;
  logic burst_boost, finishing;
  logic [5:0] taken, burst_n;
  logic [4:0] pace_cnt;
  logic start_burst;
  assign burst_n = 6'h01 << burst_code;
  assign start_burst = cs_fall && state == nao_pkg::ST_IDLE && !finishing;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= nao_pkg::ST_IDLE;
      conv_start <= 1'b0;
      finishing <= 1'b0;
      taken <= 6'h00;
      burst_code <= 3'h0;
      burst_boost <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      finishing <= 1'b0;
      case (state)
        nao_pkg::ST_IDLE: begin
          if (start_burst) begin
            state <= nao_pkg::ST_CONVERT;
            conv_start <= 1'b1;
            taken <= 6'h00;
            burst_code <= avg_on ? ratio_active : 3'h0;
            burst_boost <= avg_on && extra_resolution_enable;
          end
        end
        nao_pkg::ST_CONVERT: begin
          if (conv_done) begin
            taken <= taken + 6'h01;
            if (taken + 6'h01 == burst_n) begin
              state <= nao_pkg::ST_IDLE;
              finishing <= 1'b1;
            end else begin
              state <= nao_pkg::ST_PACE;
            end
          end
        end
        nao_pkg::ST_PACE: begin
          if (pace_cnt == 5'h00) begin
            state <= nao_pkg::ST_CONVERT;
            conv_start <= 1'b1;
          end
        end
        default: begin
          state <= nao_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Spacing between internal conversion starts
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pace_cnt <= 5'h00;
    end else if (conv_start) begin
      pace_cnt <= PACE_LAST - 5'h01;
    end else if (pace_cnt != 5'h00) begin
      pace_cnt <= pace_cnt - 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      burst_busy <= 1'b0;
    end else begin
      burst_busy <= start_burst || (state != nao_pkg::ST_IDLE && !finishing
        && !(state == nao_pkg::ST_CONVERT && conv_done && taken + 6'h01 == burst_n));
    end
  end

  // ****************************************
  // Accumulators and division
  // ****************************************
  logic [SUM_W-1:0] sum_a, sum_b;
  logic add;
  assign add = conv_done && state == nao_pkg::ST_CONVERT;

  channel_accumulator #(.SAMPLE_W(SAMPLE_W), .SUM_W(SUM_W)) acc_a (
    .clock(clock), .rst_b(rst_b), .clear(finishing), .add(add),
    .sample(sample_a), .sum(sum_a)
  );
  channel_accumulator #(.SAMPLE_W(SAMPLE_W), .SUM_W(SUM_W)) acc_b (
    .clock(clock), .rst_b(rst_b), .clear(finishing), .add(add),
    .sample(sample_b), .sum(sum_b)
  );

  logic signed [SUM_W-1:0] quo_a, quo_b;
  always_comb begin
    quo_a = burst_boost ? $signed(sum_a << `BOOST_BITS) : $signed(sum_a);
    quo_b = burst_boost ? $signed(sum_b << `BOOST_BITS) : $signed(sum_b);
    quo_a = quo_a >>> burst_code;
    quo_b = quo_b >>> burst_code;
  end

  // ****************************************
  // Serial readout
  // ****************************************
  logic [OUT_W-1:0] shift_a, shift_b;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shift_a <= '0;
      shift_b <= '0;
      result_bits <= 5'(SAMPLE_W);
    end else if (finishing) begin
      shift_a <= burst_boost ? quo_a[OUT_W-1:0] : {quo_a[SAMPLE_W-1:0], 2'h0};
      shift_b <= burst_boost ? quo_b[OUT_W-1:0] : {quo_b[SAMPLE_W-1:0], 2'h0};
      result_bits <= burst_boost ? 5'(OUT_W) : 5'(SAMPLE_W);
    end else if (sclk_fall) begin
      shift_a <= {shift_a[OUT_W-2:0], 1'b0};
      shift_b <= {shift_b[OUT_W-2:0], 1'b0};
    end
  end
  assign sdo_a = shift_a[OUT_W-1];
  assign sdo_b = shift_b[OUT_W-1];

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      result_ready <= 1'b0;
    end else if (finishing) begin
      result_ready <= 1'b1;
    end else if (cs_fall) begin
      result_ready <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [4:0] gap;
  always_ff @(posedge clock) begin
    if (!rst_b) gap <= 5'h00;
    else if (conv_start) gap <= 5'h01;
    else if (gap != 5'h1f) gap <= gap + 5'h01;
  end

  property p_pace;
    @(posedge clock) disable iff (!rst_b)
      conv_start && $past(state) == nao_pkg::ST_PACE |-> gap >= 5'(`PACE_CYCLES);
  endproperty
  a_pace: assert property (p_pace) else $error("internal start too early");

  property p_first;
    @(posedge clock) disable iff (!rst_b)
      start_burst |=> conv_start && state == nao_pkg::ST_CONVERT;
  endproperty
  a_first: assert property (p_first) else $error("burst not started");

  property p_ignore;
    @(posedge clock) disable iff (!rst_b)
      cs_fall && state != nao_pkg::ST_IDLE |=> $stable(burst_code) && $stable(burst_boost);
  endproperty
  a_ignore: assert property (p_ignore) else $error("busy burst restarted");

  property p_count;
    @(posedge clock) disable iff (!rst_b)
      finishing |-> taken == burst_n;
  endproperty
  a_count: assert property (p_count) else $error("wrong sample count");

  property p_clear;
    @(posedge clock) disable iff (!rst_b)
      finishing |=> sum_a == '0 && sum_b == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("sums not cleared");

  property p_latency;
    @(posedge clock) disable iff (!rst_b)
      setup_write ##1 (!conv_done && !setup_write) [*2] |-> $stable(ratio_active);
  endproperty
  a_latency: assert property (p_latency) else $error("ratio applied early");

  property p_mode;
    @(posedge clock) disable iff (!rst_b)
      start_burst && (style || ratio_active == 3'h0) |=> burst_code == 3'h0 && !burst_boost;
  endproperty
  a_mode: assert property (p_mode) else $error("averaging without valid mode");

  property p_width;
    @(posedge clock) disable iff (!rst_b)
      finishing |=> result_ready && result_bits == (burst_boost ? 5'(OUT_W) : 5'(SAMPLE_W));
  endproperty
  a_width: assert property (p_width) else $error("result width wrong");

  property p_msb;
    @(posedge clock) disable iff (!rst_b)
      sclk_fall && !finishing |=> shift_a == ($past(shift_a) << 1)
        && shift_b == ($past(shift_b) << 1);
  endproperty
  a_msb: assert property (p_msb) else $error("shift order wrong");

  cover property (@(posedge clock) disable iff (!rst_b) finishing && burst_code == 3'h5);
  cover property (@(posedge clock) disable iff (!rst_b) cs_fall && state == nao_pkg::ST_PACE);
  cover property (@(posedge clock) disable iff (!rst_b) finishing && burst_boost);
endmodule

//--- testbench/converter_core_model.sv
// Behavioural conversion core facing the oversampling engine.
// Assumes conv_start is a one-cycle pulse on the shared clock.
`timescale 1ns/10ps
module converter_core_model (
  input wire logic clock,
  input wire logic conv_start,
  input wire logic fast,
  output logic conv_done,
  output logic [15:0] sample_a,
  output logic [15:0] sample_b
);
  int g = 0;
  initial begin
    conv_done = 1'b0;
    sample_a = 16'h0000;
    sample_b = 16'h0000;
  end
  // Sample k of the run is a fixed ramp per channel
  always @(posedge clock) begin
    if (conv_start === 1'b1) begin
      repeat (fast ? 2 : 200) @(posedge clock);
      #2;
      conv_done = 1'b1;
      sample_a = 16'(g * 37 - 1000);
      sample_b = 16'(-g * 53 - 7);
      @(posedge clock);
      #2;
      conv_done = 1'b0;
      // Data not valid outside the strobe
      sample_a = ~sample_a;
      sample_b = ~sample_b;
      g++;
    end
  end
endmodule

//--- testbench/normal_average_oversampler_tb_top.sv
// Self-checking bench of the normal-average oversampling engine.
// Assumes the core model answers every conv_start with one sample pair.
`timescale 1ns/10ps
module normal_average_oversampler_tb_top;
  logic clock = 1'b0, rst_b = 1'b0, setup_write = 1'b0, fast = 1'b0;
  logic [15:0] setup_data = 16'h0000;
  logic extra_resolution_enable = 1'b0, cs_b = 1'b1, sclk = 1'b0;
  logic conv_start, conv_done, sdo_a, sdo_b, result_ready;
  logic burst_busy, rolling_selected;
  logic [15:0] sample_a, sample_b;
  logic [4:0] result_bits;
  int errors = 0, check_count = 0, starts = 0, cyc = 0, last = -1;
  always #12.5 clock = ~clock;
  normal_average_oversampler #(.SAMPLE_W(16)) i_dut (.clock(clock), .rst_b(rst_b),
    .setup_write(setup_write), .setup_data(setup_data),
    .extra_resolution_enable(extra_resolution_enable), .cs_b(cs_b), .sclk(sclk),
    .conv_start(conv_start), .conv_done(conv_done), .sample_a(sample_a),
    .sample_b(sample_b), .sdo_a(sdo_a), .sdo_b(sdo_b), .result_ready(result_ready),
    .result_bits(result_bits), .burst_busy(burst_busy),
    .rolling_selected(rolling_selected));
  converter_core_model i_core (.clock(clock), .conv_start(conv_start), .fast(fast),
    .conv_done(conv_done), .sample_a(sample_a), .sample_b(sample_b));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Internal starts of one burst keep the pacing
  always @(posedge clock) begin
    cyc++;
    if (conv_start === 1'b1) begin
      if (last >= 0) check("pace", 18'h1, 18'(cyc - last >= 14));
      last = cyc;
      starts++;
    end else if (burst_busy !== 1'b1) last = -1;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #2;
    end
  endtask
  task automatic setup(input logic [15:0] w);
    setup_data = w;
    setup_write = 1'b1;
    step(1);
    setup_write = 1'b0;
  endtask
  function automatic logic [17:0] expect_word(input int g0, input int n, input int sh,
      input bit bst, input bit chan_b);
    longint s;
    s = 0;
    for (int i = 0; i < n; i++) s += chan_b ? -(g0 + i) * 53 - 7 : (g0 + i) * 37 - 1000;
    if (bst) s = s * 4;
    s = s >>> sh;
    return bst ? 18'(s) : {2'h0, 16'(s)};
  endfunction
  // One host access: cs fall, optional readout, then wait out the burst
  task automatic access(input int bits, input bit poke, output logic [17:0] wa,
      output logic [17:0] wb, output int n);
    int s0, t;
    s0 = starts;
    wa = '0;
    wb = '0;
    cs_b = 1'b0;
    step(1);
    for (int i = 0; i < bits; i++) begin
      wa = {wa[16:0], sdo_a};
      wb = {wb[16:0], sdo_b};
      sclk = 1'b1;
      step(3);
      sclk = 1'b0;
      step(5);
    end
    cs_b = 1'b1;
    t = 0;
    while (burst_busy !== 1'b1 && t < 10) begin
      step(1);
      t++;
    end
    if (poke) begin
      step(30);
      cs_b = 1'b0;
      step(2);
      cs_b = 1'b1;
    end
    t = 0;
    while (burst_busy !== 1'b0 && t < 8000) begin
      step(1);
      t++;
    end
    if (t >= 8000) check("burst_end", 18'h0, 18'h1);
    step(20);
    n = starts - s0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic check_reset;
    check("conv_start", 18'h0, conv_start);
    check("result_ready", 18'h0, result_ready);
    check("burst_busy", 18'h0, burst_busy);
    check("rolling", 18'h0, rolling_selected);
    check("bits_reset", 18'h10, result_bits);
  endtask
  task automatic run_code(input logic [2:0] c);
    logic [17:0] wa, wb;
    int n, g0, nn, sh;
    bit bst;
    nn = (c >= 3'h1 && c <= 3'h5) ? (1 << c) : 1;
    sh = (nn > 1) ? int'(c) : 0;
    bst = (c[0] | c[2]) && nn > 1;
    extra_resolution_enable = c[0] | c[2];
    setup({6'h00, 1'b0, c, 6'h00});
    access(0, 0, wa, wb, n);
    check("held_1", 18'h1, 18'(n));
    access(0, 0, wa, wb, n);
    check("held_2", 18'h1, 18'(n));
    fast = 1'b1;
    g0 = starts;
    access(0, c == 3'h5, wa, wb, n);
    check("burst_len", 18'(nn), 18'(n));
    check("ready", 18'h1, result_ready);
    check("bits", bst ? 18'h12 : 18'h10, result_bits);
    fast = 1'b0;
    access(bst ? 18 : 16, 0, wa, wb, n);
    check("avg_a", expect_word(g0, nn, sh, bst, 0), wa);
    check("avg_b", expect_word(g0, nn, sh, bst, 1), wb);
    setup(16'h0000);
    access(0, 0, wa, wb, n);
  endtask
  // Early pin activity, results ignored
  task automatic run_early;
    cs_b = 1'b0;
    step(1);
    cs_b = 1'b1;
    sclk = 1'b1;
    step(2);
    sclk = 1'b0;
    step(300);
    check("early_idle", 18'h0, burst_busy);
    check("early_starts", 18'h1, 18'(starts));
  endtask
  task automatic run_rolling;
    logic [17:0] wa, wb;
    int n;
    extra_resolution_enable = 1'b0;
    setup(16'h0240);
    access(0, 0, wa, wb, n);
    access(0, 0, wa, wb, n);
    check("rolling_on", 18'h1, rolling_selected);
    access(0, 0, wa, wb, n);
    check("rolling_len", 18'h1, 18'(n));
    setup(16'h0000);
    access(0, 0, wa, wb, n);
    access(0, 0, wa, wb, n);
    check("rolling_off", 18'h0, rolling_selected);
  endtask
  initial begin
    #(25 * 90000);
    errors++;
    end_of_test;
  end
  initial begin
    step(16);
    rst_b = 1'b1;
    check_reset;
    run_early;
    for (int c = 1; c <= 6; c++) run_code(3'(c));
    run_rolling;
    end_of_test;
  end
endmodule
